// ==== rtl/watchdog_reset_flag_defines.svh ====
`ifndef WATCHDOG_RESET_FLAG_DEFINES_SVH
`define WATCHDOG_RESET_FLAG_DEFINES_SVH

// ==========================================================
// Register offsets (byte addresses)
`define WATCHDOG_RESET_FLAG_CAUSE_OFS 8'h00
`define WATCHDOG_RESET_FLAG_CTRL_OFS 8'h04
`define WATCHDOG_RESET_FLAG_RESTART_OFS 8'h08
`define WATCHDOG_RESET_FLAG_CFG_OFS 8'h0c
`define WATCHDOG_RESET_FLAG_COUNT_OFS 8'h10

// ==========================================================
// Reset-cause field positions
`define WATCHDOG_RESET_FLAG_POR_BIT 0
`define WATCHDOG_RESET_FLAG_EXT_BIT 1
`define WATCHDOG_RESET_FLAG_WDF_BIT 3

// ==========================================================
// Control and config field positions
`define WATCHDOG_RESET_FLAG_IRQF_BIT 7
`define WATCHDOG_RESET_FLAG_IRQEN_BIT 6
`define WATCHDOG_RESET_FLAG_TSEL3_BIT 5
`define WATCHDOG_RESET_FLAG_UNLOCK_BIT 4
`define WATCHDOG_RESET_FLAG_RSTEN_BIT 3
`define WATCHDOG_RESET_FLAG_CLKMON_BIT 0

// ==========================================================
// Reset values
`define WATCHDOG_RESET_FLAG_CAUSE_RST 8'h01
`define WATCHDOG_RESET_FLAG_CTRL_RST 8'h00
`define WATCHDOG_RESET_FLAG_TSEL_RST 4'h0

// ==========================================================
// Timing
`define WATCHDOG_RESET_FLAG_CLK_HZ 100000000
`define WATCHDOG_RESET_FLAG_OSC_HZ 128000
`define WATCHDOG_RESET_FLAG_UNLOCK_CYC 3'h4
`define WATCHDOG_RESET_FLAG_BASE_SHIFT 5'h0b
`define WATCHDOG_RESET_FLAG_TSEL_MAX 4'h9
`define WATCHDOG_RESET_FLAG_TMIN_MS 16
`define WATCHDOG_RESET_FLAG_TMAX_MS 8000

`endif

// ==== rtl/watchdog_reset_flag_pkg.sv ====
package watchdog_reset_flag_pkg;
  typedef enum logic [1:0] {
    WATCHDOG_RESET_FLAG_STOPPED = 2'b00,
    WATCHDOG_RESET_FLAG_IRQ     = 2'b01,
    WATCHDOG_RESET_FLAG_RST     = 2'b10,
    WATCHDOG_RESET_FLAG_IRQRST  = 2'b11
  } watchdog_reset_flag_mode_type;
endpackage

// ==== rtl/watchdog_reset_flag_sync.sv ====
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for asynchronous levels
module watchdog_reset_flag_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_chk
    $error("watchdog_reset_flag_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// ==== rtl/watchdog_reset_flag_cnt.sv ====
`timescale 1ns/10ps
// ==========================================================
// Oscillator tick counter with programmable expiry
module watchdog_reset_flag_cnt #(
  parameter int CW = 21
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic clr,
  input wire logic [CW-1:0] limit,
  output logic [CW-1:0] count_q,
  output logic expire_q
);
  logic [CW-1:0] count_d;
  logic expire_d;
  logic at_end;

  if (CW < 21) begin : g_chk
    $error("watchdog_reset_flag_cnt: CW too small for the longest period");
  end

  assign at_end = (count_q == limit - CW'(1));

  always_comb begin
    count_d = count_q;
    expire_d = 1'b0;
    if (clr || !run) begin
      count_d = '0;
    end else if (tick) begin
      if (at_end) begin
        count_d = '0;
        expire_d = 1'b1;
      end else begin
        count_d = count_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_q <= '0;
      expire_q <= 1'b0;
    end else if (ce) begin
      count_q <= count_d;
      expire_q <= expire_d;
    end
  end
endmodule

// ==== rtl/watchdog_reset_flag_top.sv ====
// Contract
// RULE_01: External reset sets flag; POR or zero-write clears.
// RULE_02: POR sets power-on flag; only zero-write clears.
// RULE_03: Software reads then clears cause flags early.
// RULE_04: Counter advances on 128 kHz oscillator ticks.
// RULE_05: Expiry at selected value; restart zeroes counter.
// RULE_06: Four modes: irq, reset, both, clock monitor; code modes are stopped, irq, reset, both.
// RULE_07: Interrupt mode: interrupt only, no reset.
// RULE_08: Reset mode: expiry asserts device reset.
// RULE_09: Combined: first interrupt, later expiry resets.
// RULE_10: Fuse forces reset enable one, irq zero.
// RULE_11: Unlock needs unlock and reset enable together.
// RULE_12: Change accepted only within four-cycle window.
// RULE_13: Periods span 16 ms to 8 s.
// RULE_14: Watchdog stays enabled after its own reset.
// RULE_15: Software restarts counter before period change.
// RULE_16: Clock monitor configuration forces reset mode.
// RULE_17: Watchdog reset sets flag; POR or zero-write clears.
// RULE_18: Flag set forces reset enable to one.
// RULE_19: Unlock bit self-clears after four cycles.
// RULE_20: Select 2048 cycles doubling to 1048576.
// RULE_21: Locked fields ignore writes outside window.
// RULE_22: Expiry synchronised into system clock domain.
`timescale 1ns/10ps
`include "watchdog_reset_flag_defines.svh"
module watchdog_reset_flag_top
  import watchdog_reset_flag_pkg::*;
#(
  parameter int CW = 21,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic osc_clk_in,
  input wire logic ext_reset_seen,
  input wire logic force_on_fuse,
  input wire logic wdr_req,
  input wire logic irq_ack,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wdt_irq,
  output logic wdt_sys_reset
);
  localparam int OSC_PER_CLK = `WATCHDOG_RESET_FLAG_CLK_HZ / `WATCHDOG_RESET_FLAG_OSC_HZ;

  if (AW < 8 || OSC_PER_CLK < 4) begin : g_chk
    $error("watchdog_reset_flag_top: address too narrow or oscillator too fast");
  end

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pins_s;
  logic osc_s, ext_s, fuse_s;

  watchdog_reset_flag_sync #(.W(3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d({osc_clk_in, ext_reset_seen, force_on_fuse}),
    .q(pins_s)
  );
  assign {osc_s, ext_s, fuse_s} = pins_s;

  logic osc_prev_q, ext_prev_q;
  wire osc_tick = osc_s & ~osc_prev_q;
  wire ext_rise = ext_s & ~ext_prev_q;

  // ==========================================================
  // State
  logic por_q, ext_q, wdf_q;
  logic irqf_q, irqen_q, rsten_q, unlock_q, clkmon_q;
  logic [3:0] tsel_q;
  logic [2:0] win_q;
  logic irq_q, sysrst_q;
  logic awready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [CW-1:0] count_q;
  logic expire_q;
  wire [7:0] cause_rst = `WATCHDOG_RESET_FLAG_CAUSE_RST;

  // ==========================================================
  // Mode selection
  wire rst_eff = rsten_q | wdf_q | fuse_s | clkmon_q; // [RULE_18] [RULE_14] [RULE_10] [RULE_16]
  wire irq_eff = irqen_q & ~fuse_s & ~clkmon_q; // [RULE_10] [RULE_16]
  watchdog_reset_flag_mode_type mode;
  assign mode = watchdog_reset_flag_mode_type'({rst_eff, irq_eff}); // [RULE_06]

  // ==========================================================
  // Bus decode
  wire wr_fire = s_axi_awvalid & s_axi_wvalid & awready_q & ce;
  wire rd_fire = s_axi_arvalid & arready_q & ce;
  wire [7:0] waddr = s_axi_awaddr[7:0];
  wire [7:0] raddr = s_axi_araddr[7:0];
  wire [7:0] wd = s_axi_wdata[7:0];
  wire wlane = s_axi_wstrb[0];
  wire w_hit = (waddr == `WATCHDOG_RESET_FLAG_CAUSE_OFS) || (waddr == `WATCHDOG_RESET_FLAG_CTRL_OFS) ||
    (waddr == `WATCHDOG_RESET_FLAG_RESTART_OFS) || (waddr == `WATCHDOG_RESET_FLAG_CFG_OFS) || (waddr == `WATCHDOG_RESET_FLAG_COUNT_OFS);
  wire r_hit = (raddr == `WATCHDOG_RESET_FLAG_CAUSE_OFS) || (raddr == `WATCHDOG_RESET_FLAG_CTRL_OFS) ||
    (raddr == `WATCHDOG_RESET_FLAG_RESTART_OFS) || (raddr == `WATCHDOG_RESET_FLAG_CFG_OFS) || (raddr == `WATCHDOG_RESET_FLAG_COUNT_OFS);
  wire wr_cause = wr_fire & wlane & (waddr == `WATCHDOG_RESET_FLAG_CAUSE_OFS);
  wire wr_ctrl = wr_fire & wlane & (waddr == `WATCHDOG_RESET_FLAG_CTRL_OFS);
  wire wr_restart = wr_fire & (waddr == `WATCHDOG_RESET_FLAG_RESTART_OFS);
  wire wr_cfg = wr_fire & wlane & (waddr == `WATCHDOG_RESET_FLAG_CFG_OFS);

  wire [7:0] cause_rd = {4'h0, wdf_q, 1'b0, ext_q, por_q};
  wire [7:0] ctrl_rd = {irqf_q, irq_eff, tsel_q[3], unlock_q, rst_eff, tsel_q[2:0]}; // [RULE_18]
  logic [31:0] rd_mux;
  always_comb begin
    if (raddr == `WATCHDOG_RESET_FLAG_CAUSE_OFS) begin
      rd_mux = {24'h000000, cause_rd};
    end else if (raddr == `WATCHDOG_RESET_FLAG_CTRL_OFS) begin
      rd_mux = {24'h000000, ctrl_rd};
    end else if (raddr == `WATCHDOG_RESET_FLAG_CFG_OFS) begin
      rd_mux = {31'h0, clkmon_q};
    end else if (raddr == `WATCHDOG_RESET_FLAG_COUNT_OFS) begin
      rd_mux = 32'(count_q);
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ==========================================================
  // Protected change sequence
  wire unlock_wr = wr_ctrl & wd[`WATCHDOG_RESET_FLAG_UNLOCK_BIT] & wd[`WATCHDOG_RESET_FLAG_RSTEN_BIT]; // [RULE_11]
  wire change_ok = wr_ctrl & unlock_q & ~wd[`WATCHDOG_RESET_FLAG_UNLOCK_BIT]; // [RULE_12]
  wire win_end = unlock_q & (win_q == 3'h1);

  logic rsten_d;
  always_comb begin
    rsten_d = rsten_q;
    if (change_ok && (wd[`WATCHDOG_RESET_FLAG_RSTEN_BIT] || !wdf_q)) begin // [RULE_12] [RULE_18]
      rsten_d = wd[`WATCHDOG_RESET_FLAG_RSTEN_BIT];
    end else if (wr_ctrl && wd[`WATCHDOG_RESET_FLAG_RSTEN_BIT]) begin // [RULE_21]
      rsten_d = 1'b1;
    end
  end
  wire [3:0] tsel_d = change_ok ? {wd[`WATCHDOG_RESET_FLAG_TSEL3_BIT], wd[2:0]} : tsel_q; // [RULE_21]

  // ==========================================================
  // Period and counter
  wire [3:0] tsel_eff = (tsel_q > `WATCHDOG_RESET_FLAG_TSEL_MAX) ? `WATCHDOG_RESET_FLAG_TSEL_MAX : tsel_q;
  wire [4:0] shift = `WATCHDOG_RESET_FLAG_BASE_SHIFT + 5'(tsel_eff);
  wire [CW-1:0] limit = CW'(1) << shift; // [RULE_20] [RULE_13]
  wire restart = wdr_req | wr_restart;

  watchdog_reset_flag_cnt #(.CW(CW)) u_cnt (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .run(mode != WATCHDOG_RESET_FLAG_STOPPED),
    .tick(osc_tick), // [RULE_04] [RULE_22]
    .clr(restart), // [RULE_05]
    .limit(limit),
    .count_q(count_q),
    .expire_q(expire_q)
  );

  // ==========================================================
  // Expiry actions
  logic set_irqf, do_reset;
  always_comb begin
    set_irqf = 1'b0;
    do_reset = 1'b0;
    if (expire_q) begin
      case (mode)
        WATCHDOG_RESET_FLAG_IRQ: begin
          set_irqf = 1'b1; // [RULE_07]
        end
        WATCHDOG_RESET_FLAG_RST: begin
          do_reset = 1'b1; // [RULE_08]
        end
        WATCHDOG_RESET_FLAG_IRQRST: begin
          set_irqf = ~irqf_q; // [RULE_09]
          do_reset = irqf_q;
        end
        default: begin
          set_irqf = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      por_q <= cause_rst[`WATCHDOG_RESET_FLAG_POR_BIT]; // [RULE_02]
      ext_q <= 1'b0;
      wdf_q <= 1'b0;
      osc_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (ce) begin
      osc_prev_q <= osc_s;
      ext_prev_q <= ext_s;
      por_q <= por_q & ~(wr_cause & ~wd[`WATCHDOG_RESET_FLAG_POR_BIT]); // [RULE_02]
      ext_q <= ext_rise | (ext_q & ~(wr_cause & ~wd[`WATCHDOG_RESET_FLAG_EXT_BIT])); // [RULE_01]
      wdf_q <= do_reset | (wdf_q & ~(wr_cause & ~wd[`WATCHDOG_RESET_FLAG_WDF_BIT])); // [RULE_17]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqf_q <= 1'b0;
      irqen_q <= 1'b0;
      rsten_q <= 1'b0;
      tsel_q <= `WATCHDOG_RESET_FLAG_TSEL_RST;
      clkmon_q <= 1'b0;
      irq_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else if (ce) begin
      irqf_q <= set_irqf | (irqf_q & ~(wr_ctrl & wd[`WATCHDOG_RESET_FLAG_IRQF_BIT]) & ~irq_ack);
      irqen_q <= wr_ctrl ? wd[`WATCHDOG_RESET_FLAG_IRQEN_BIT] : (irqen_q & ~(irq_ack & rst_eff)); // [RULE_09]
      rsten_q <= rsten_d;
      tsel_q <= tsel_d;
      clkmon_q <= wr_cfg ? wd[`WATCHDOG_RESET_FLAG_CLKMON_BIT] : clkmon_q;
      irq_q <= (set_irqf | irqf_q) & irq_eff; // [RULE_07]
      sysrst_q <= do_reset;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      unlock_q <= 1'b0;
      win_q <= 3'h0;
    end else if (ce) begin
      if (unlock_wr) begin
        unlock_q <= 1'b1;
        win_q <= `WATCHDOG_RESET_FLAG_UNLOCK_CYC;
      end else if (win_end) begin
        unlock_q <= 1'b0; // [RULE_19]
        win_q <= 3'h0;
      end else if (unlock_q) begin
        win_q <= win_q - 3'h1;
      end
    end
  end

  // ==========================================================
  // Bus slave handshakes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= 2'b00;
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      if (wr_fire) begin
        awready_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
        awready_q <= 1'b1;
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= r_hit ? 2'b00 : 2'b10;
        rdata_q <= rd_mux;
      end else if (rvalid_q && s_axi_rready) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wdt_irq = irq_q;
  assign wdt_sys_reset = sysrst_q;

  // ==========================================================
  // Assertions
  por_after_reset_a: assert property (@(posedge clk) !nrst |=> por_q) // [RULE_02]
    else $error("power-on flag not set after reset");
  ext_flag_set_a: assert property (@(posedge clk) disable iff (!nrst) ext_rise && ce |=> ext_q) // [RULE_01]
    else $error("external flag missed");
  wdf_on_reset_a: assert property (@(posedge clk) disable iff (!nrst) sysrst_q |-> wdf_q) // [RULE_17]
    else $error("watchdog flag not set with reset");
  fuse_forces_a: assert property (@(posedge clk) disable iff (!nrst) fuse_s |-> rst_eff && !irq_eff) // [RULE_10]
    else $error("fuse did not force reset mode");
  wdf_holds_en_a: assert property (@(posedge clk) disable iff (!nrst) wdf_q |-> ctrl_rd[`WATCHDOG_RESET_FLAG_RSTEN_BIT]) // [RULE_18]
    else $error("reset enable reads zero while flag set");
  unlock_expiry_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(unlock_q) && ce && !unlock_wr) ##1 (ce && !unlock_wr)[*3] |=> !unlock_q) // [RULE_19]
    else $error("unlock bit did not clear after four cycles");
  tsel_locked_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $changed(tsel_q) |-> $past(unlock_q)) // [RULE_21]
    else $error("period select changed outside window");
  rsten_locked_a: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $fell(rsten_q) |-> $past(unlock_q) && !$past(wdf_q)) // [RULE_12]
    else $error("reset enable cleared outside window");
  irq_only_a: assert property (@(posedge clk) disable iff (!nrst)
    expire_q && ce && mode == WATCHDOG_RESET_FLAG_IRQ |=> irqf_q && !sysrst_q) // [RULE_07]
    else $error("interrupt mode misbehaved");
  reset_mode_a: assert property (@(posedge clk) disable iff (!nrst)
    expire_q && ce && mode == WATCHDOG_RESET_FLAG_RST |=> sysrst_q ##1 (!sysrst_q || !ce)) // [RULE_08]
    else $error("reset mode gave no one-cycle reset");
  combined_first_a: assert property (@(posedge clk) disable iff (!nrst)
    expire_q && ce && mode == WATCHDOG_RESET_FLAG_IRQRST && !irqf_q |=> irqf_q && !sysrst_q) // [RULE_09]
    else $error("combined mode first expiry wrong");
  restart_zero_a: assert property (@(posedge clk) disable iff (!nrst) restart && ce |=> count_q == '0) // [RULE_05]
    else $error("restart did not zero counter");

  irq_seen_c: cover property (@(posedge clk) disable iff (!nrst) $rose(wdt_irq));
  reset_seen_c: cover property (@(posedge clk) disable iff (!nrst) $rose(wdt_sys_reset));
  change_seen_c: cover property (@(posedge clk) disable iff (!nrst) change_ok && ce);
endmodule

// ==== verification/watchdog_reset_flag_bench.sv ====
`timescale 1ns/10ps
`include "watchdog_reset_flag_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module watchdog_reset_flag_bench;
  logic clk, nrst, ce, osc, ext, fuse, wdr, ack;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb;
  logic wdt_irq, wdt_sys_reset;
  int n_fail, checks, n_rst;

  watchdog_reset_flag_top dut (.clk(clk), .nrst(nrst), .ce(ce), .osc_clk_in(osc), .ext_reset_seen(ext),
    .force_on_fuse(fuse), .wdr_req(wdr), .irq_ack(ack), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wdt_irq(wdt_irq), .wdt_sys_reset(wdt_sys_reset));

  // ==========================================================
  // Clocks and monitors
  always #5 clk = ~clk;
  // Watchdog oscillator sped up: 8 system cycles per tick
  always #40 osc = ~osc;
  always @(posedge clk) begin
    if (wdt_sys_reset === 1'b1) n_rst++;
  end

  // ==========================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rdv = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic kick();
    @(posedge clk);
    wdr <= 1'b1;
    @(posedge clk);
    wdr <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h01)
    `CHK(resp, 2'b00)
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    wstrb <= 4'h0;
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0008);
    wstrb <= 4'hf;
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    wr(8'h14, 32'h0000_0000);
    `CHK(resp, 2'b10)
    rdr(8'h14);
    `CHK(resp, 2'b10)
    `CHK(rdv, 32'h0000_0000)
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h01)
    $display("done reset values");
  endtask

  task automatic t_flags();
    wr(`WATCHDOG_RESET_FLAG_CAUSE_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h00)
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h02)
    wr(`WATCHDOG_RESET_FLAG_CAUSE_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h00)
    $display("done reset flags");
  endtask

  task automatic t_unlock();
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0008);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h08)
    kick();
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0001);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h01)
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h19)
    repeat (4) @(posedge clk);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h09)
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h09)
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    $display("done unlock window");
  endtask

  task automatic t_irq();
    int i;
    kick();
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0040);
    repeat (600 * 8) @(posedge clk);
    kick();
    repeat (2030 * 8) @(posedge clk);
    `CHK(wdt_irq, 1'b0)
    for (i = 0; i < 400 && wdt_irq !== 1'b1; i++) @(posedge clk);
    `CHK(wdt_irq, 1'b1)
    `CHK(n_rst, 0)
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'hc0)
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(wdt_irq, 1'b0)
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    $display("done interrupt mode");
  endtask

  task automatic t_rst();
    int i;
    kick();
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0008);
    for (i = 0; i < 17000 && wdt_sys_reset !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK(wdt_sys_reset, 1'b0)
    `CHK(n_rst, 1)
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h08)
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h08)
    wr(`WATCHDOG_RESET_FLAG_CAUSE_OFS, 32'h0000_0000);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    $display("done reset mode");
  endtask

  task automatic t_combo();
    int i;
    kick();
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0048);
    for (i = 0; i < 17000 && wdt_irq !== 1'b1; i++) @(posedge clk);
    `CHK(wdt_irq, 1'b1)
    `CHK(n_rst, 1)
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'hc8)
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h08)
    for (i = 0; i < 17000 && wdt_sys_reset !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK(n_rst, 2)
    `CHK(wdt_irq, 1'b0)
    rdr(`WATCHDOG_RESET_FLAG_CAUSE_OFS);
    `CHK(rdv[7:0], 8'h08)
    wr(`WATCHDOG_RESET_FLAG_CAUSE_OFS, 32'h0000_0000);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0018);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    $display("done combined mode");
  endtask

  task automatic t_fuse();
    fuse <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0040);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h08)
    fuse <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`WATCHDOG_RESET_FLAG_CFG_OFS, 32'h0000_0001);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h08)
    rdr(`WATCHDOG_RESET_FLAG_CFG_OFS);
    `CHK(rdv[7:0], 8'h01)
    wr(`WATCHDOG_RESET_FLAG_CFG_OFS, 32'h0000_0000);
    wr(`WATCHDOG_RESET_FLAG_CTRL_OFS, 32'h0000_0000);
    rdr(`WATCHDOG_RESET_FLAG_CTRL_OFS);
    `CHK(rdv[7:0], 8'h00)
    $display("done fuse and clock monitor");
  endtask

  // ==========================================================
  // Verdict and sequence
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #900000;
    n_fail++;
    $display("BAD %0t timeout", $time);
    finish_test();
  end

  initial begin
    clk = 1'b0;
    osc = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    ext = 1'b0;
    fuse = 1'b0;
    wdr = 1'b0;
    ack = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_flags();
    t_unlock();
    t_irq();
    t_rst();
    t_combo();
    t_fuse();
    finish_test();
  end
endmodule
